// >>> rtl/eeprom_port_pkg.sv
// Constants for the host controller of a latched byte-wide EEPROM.
// Assumes a 100 MHz core clock; all pin timing is counted in its cycles.
package eeprom_port_pkg;
   // =====================================================
   // Clock
   localparam int CLK_MHZ            = 100;
   // =====================================================
   // Geometry
   localparam int ADDR_W             = 11;
   localparam int DATA_W             = 8;
   // =====================================================
   // Times as printed
   localparam int SETUP_NS           = 50;
   localparam int HOLD_NS            = 50;
   localparam int STROBE_LOW_STD_MS  = 9;
   localparam int STROBE_LOW_FAST_MS = 1;
   localparam int CHIP_STROBE_MS     = 10;
   localparam int CHIP_SETUP_US      = 1;
   localparam int RECOVERY_READ_US   = 2;
   localparam int READ_ACCESS_NS     = 250;
   // =====================================================
   // Cycle counts, least times rounded up
   localparam int SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC       = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int CHIP_SETUP_CYC = CHIP_SETUP_US * CLK_MHZ;
   localparam int RECOVERY_CYC   = RECOVERY_READ_US * CLK_MHZ;
   localparam int READ_CYC       = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_STD_CYC  = STROBE_LOW_STD_MS * 1000 * CLK_MHZ;
   localparam int STROBE_FAST_CYC = STROBE_LOW_FAST_MS * 1000 * CLK_MHZ;
   localparam int STROBE_CHIP_CYC = CHIP_STROBE_MS * 1000 * CLK_MHZ;
   // =====================================================
   // Commands
   typedef enum logic [1:0] {
      CMD_READ, CMD_ERASE, CMD_WRITE, CMD_CHIP_ERASE
   } cmd_t;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int CNT_W = 24;
endpackage : eeprom_port_pkg

// >>> rtl/eeprom_host_ctrl.sv
// Host-side sequencer for a latched 2K x 8 EEPROM with strobe-started writes.
// Assumes commands arrive synchronous to core_clk and pins are registered here.
// =====================================================
// What this block does
// - Host erases byte before writing it; CMD_WRITE here issues no erase of its own
// - Erase: select low, gate high, data ones
// - Write same as erase, true data
// - Chip erase: gate at high voltage
// - Read: strobe high, select and gate low
// - Next mode only after recovery interval following erase or write; none after a read
// - Strobe low 9 ms, fast part 1 ms, chip erase 10 ms
module eeprom_host_ctrl #(
   parameter int STROBE_STD_CYC  = eeprom_port_pkg::STROBE_STD_CYC,
   parameter int STROBE_FAST_CYC = eeprom_port_pkg::STROBE_FAST_CYC,
   parameter int STROBE_CHIP_CYC = eeprom_port_pkg::STROBE_CHIP_CYC
) (
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   input  wire logic                                fast_part,
   input  wire logic                                req_valid,
   input  wire eeprom_port_pkg::cmd_t               req_cmd,
   input  wire logic [eeprom_port_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [eeprom_port_pkg::DATA_W-1:0]  req_data,
   output logic                                     req_ready,
   output logic                                     rsp_valid,
   output logic      [eeprom_port_pkg::DATA_W-1:0]  rsp_data,
   output logic      [eeprom_port_pkg::ADDR_W-1:0]  mem_addr,
   output logic                                     chip_sel_n,
   output logic                                     out_gate_n,
   output logic                                     bulk_erase_gate_level,
   output logic                                     write_strobe_n,
   input  wire logic [eeprom_port_pkg::DATA_W-1:0]  mem_data_in,
   output logic      [eeprom_port_pkg::DATA_W-1:0]  mem_data_out,
   output logic                                     mem_data_oe_n
);
   // =====================================================
   // State
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RECOVER, ST_READ
   } state_t;

   localparam int CW = eeprom_port_pkg::CNT_W;

   state_t                               state_r, state_nxt;
   logic [CW-1:0]                        cnt_r, cnt_nxt;
   eeprom_port_pkg::cmd_t                cmd_r, cmd_nxt;
   logic                                 ready_r, ready_nxt;
   logic                                 rvalid_r, rvalid_nxt;
   logic [eeprom_port_pkg::DATA_W-1:0]   rdata_r, rdata_nxt;
   logic [eeprom_port_pkg::ADDR_W-1:0]   addr_r, addr_nxt;
   logic                                 cs_n_r, cs_n_nxt;
   logic                                 og_n_r, og_n_nxt;
   logic                                 hv_r, hv_nxt;
   logic                                 we_n_r, we_n_nxt;
   logic [eeprom_port_pkg::DATA_W-1:0]   dout_r, dout_nxt;
   logic                                 oe_n_r, oe_n_nxt;
   logic [CW-1:0]                        strobe_len;

   always_comb begin
      if (cmd_r == eeprom_port_pkg::CMD_CHIP_ERASE) begin
         strobe_len = CW'(STROBE_CHIP_CYC);
      end else if (fast_part) begin
         strobe_len = CW'(STROBE_FAST_CYC);
      end else begin
         strobe_len = CW'(STROBE_STD_CYC);
      end
   end

   // =====================================================
   // Sequencer
   always_comb begin
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      cmd_nxt    = cmd_r;
      ready_nxt  = 1'b0;
      rvalid_nxt = 1'b0;
      rdata_nxt  = rdata_r;
      addr_nxt   = addr_r;
      cs_n_nxt   = cs_n_r;
      og_n_nxt   = og_n_r;
      hv_nxt     = hv_r;
      we_n_nxt   = 1'b1;
      dout_nxt   = dout_r;
      oe_n_nxt   = oe_n_r;
      case (state_r)
         ST_IDLE: begin
            cs_n_nxt  = 1'b1;
            og_n_nxt  = 1'b1;
            hv_nxt    = 1'b0;
            oe_n_nxt  = 1'b1;
            ready_nxt = 1'b1;
            if (req_valid && ready_r) begin
               ready_nxt = 1'b0;
               cmd_nxt   = req_cmd;
               addr_nxt  = req_addr;
               cs_n_nxt  = 1'b0;
               cnt_nxt   = '0;
               if (req_cmd == eeprom_port_pkg::CMD_READ) begin
                  og_n_nxt  = 1'b0;
                  state_nxt = ST_READ;
               end else begin
                  og_n_nxt  = 1'b1;
                  hv_nxt    = (req_cmd == eeprom_port_pkg::CMD_CHIP_ERASE);
                  dout_nxt  = (req_cmd == eeprom_port_pkg::CMD_WRITE) ? req_data
                              : eeprom_port_pkg::ERASED_BYTE;
                  oe_n_nxt  = 1'b0;
                  state_nxt = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            cnt_nxt = cnt_r + CW'(1);
            if ((cmd_r == eeprom_port_pkg::CMD_CHIP_ERASE
                 && cnt_r >= CW'(eeprom_port_pkg::CHIP_SETUP_CYC - 1))
                || (cmd_r != eeprom_port_pkg::CMD_CHIP_ERASE
                 && cnt_r >= CW'(eeprom_port_pkg::SETUP_CYC - 1))) begin
               we_n_nxt  = 1'b0;
               cnt_nxt   = '0;
               state_nxt = ST_STROBE;
            end
         end
         ST_STROBE: begin
            // own timer, no completion flag exists
            we_n_nxt = 1'b0;
            cnt_nxt  = cnt_r + CW'(1);
            if (cnt_r >= strobe_len - CW'(1)) begin
               we_n_nxt  = 1'b1;
               cnt_nxt   = '0;
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            cnt_nxt = cnt_r + CW'(1);
            if (cnt_r >= CW'(eeprom_port_pkg::HOLD_CYC - 1)) begin
               cs_n_nxt  = 1'b1;
               og_n_nxt  = 1'b1;
               hv_nxt    = 1'b0;
               oe_n_nxt  = 1'b1;
               cnt_nxt   = '0;
               state_nxt = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            cnt_nxt = cnt_r + CW'(1);
            if (cnt_r >= CW'(eeprom_port_pkg::RECOVERY_CYC - 1)) begin
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_READ: begin
            cnt_nxt = cnt_r + CW'(1);
            if (cnt_r >= CW'(eeprom_port_pkg::READ_CYC - 1)) begin
               rdata_nxt  = mem_data_in;
               rvalid_nxt = 1'b1;
               cs_n_nxt   = 1'b1;
               og_n_nxt   = 1'b1;
               ready_nxt  = 1'b1;
               state_nxt  = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r  <= ST_IDLE;
         cnt_r    <= '0;
         cmd_r    <= eeprom_port_pkg::CMD_READ;
         ready_r  <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         addr_r   <= '0;
         cs_n_r   <= 1'b1;
         og_n_r   <= 1'b1;
         hv_r     <= 1'b0;
         we_n_r   <= 1'b1;
         dout_r   <= '0;
         oe_n_r   <= 1'b1;
      end else begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         cmd_r    <= cmd_nxt;
         ready_r  <= ready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r  <= rdata_nxt;
         addr_r   <= addr_nxt;
         cs_n_r   <= cs_n_nxt;
         og_n_r   <= og_n_nxt;
         hv_r     <= hv_nxt;
         we_n_r   <= we_n_nxt;
         dout_r   <= dout_nxt;
         oe_n_r   <= oe_n_nxt;
      end
   end

   assign req_ready             = ready_r;
   assign rsp_valid             = rvalid_r;
   assign rsp_data              = rdata_r;
   assign mem_addr              = addr_r;
   assign chip_sel_n            = cs_n_r;
   assign out_gate_n            = og_n_r;
   assign bulk_erase_gate_level = hv_r;
   assign write_strobe_n        = we_n_r;
   assign mem_data_out          = dout_r;
   assign mem_data_oe_n         = oe_n_r;

   // =====================================================
   // Checks
   sequence s_strobe_fall;
      $fell(we_n_r);
   endsequence

   a_read_levels: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == ST_READ) |-> (we_n_r && !og_n_r && !cs_n_r && oe_n_r))
      else $error("read levels wrong");

   // erase data all ones at strobe
   a_erase_data: assert property (@(posedge core_clk) disable iff (rst)
      s_strobe_fall and (cmd_r == eeprom_port_pkg::CMD_ERASE) |->
      (dout_r == eeprom_port_pkg::ERASED_BYTE && !oe_n_r && og_n_r && !cs_n_r))
      else $error("erase data not all ones");

   a_chip_gate: assert property (@(posedge core_clk) disable iff (rst)
      s_strobe_fall |-> (hv_r == (cmd_r == eeprom_port_pkg::CMD_CHIP_ERASE)))
      else $error("high-voltage gate mismatch");

   a_hold_stable: assert property (@(posedge core_clk) disable iff (rst)
      $rose(we_n_r) |-> !cs_n_r && $stable(addr_r) && $stable(dout_r))
      else $error("inputs changed in hold");

   a_recover_ready: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == ST_RECOVER) |-> !ready_r)
      else $error("ready during recovery");

   a_idle_standby: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> (cs_n_r && oe_n_r && we_n_r))
      else $error("idle not in standby");

   // strobe stays low for at least 8 cycles
   a_strobe_width: assert property (@(posedge core_clk) disable iff (rst)
      s_strobe_fall |-> !we_n_r [*8])
      else $error("strobe too short");

   a_strobe_end: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == ST_STROBE && cnt_r == strobe_len - CW'(1)) |=> $rose(we_n_r))
      else $error("strobe end mistimed");
endmodule : eeprom_host_ctrl

// >>> dv/eeprom_dev_model.sv
// Behavioural model of the latched byte-wide EEPROM on the host's pins.
// Assumes supply always in range; host drives data only while oe_n is low.
module eeprom_dev_model (
   mem_addr,
   chip_sel_n,
   out_gate_n,
   bulk_erase_gate_level,
   write_strobe_n,
   host_data,
   host_oe_n,
   bus_level
);
   input  wire logic [eeprom_port_pkg::ADDR_W-1:0] mem_addr;
   input  wire logic                               chip_sel_n;
   input  wire logic                               out_gate_n;
   input  wire logic                               bulk_erase_gate_level;
   input  wire logic                               write_strobe_n;
   input  wire logic [eeprom_port_pkg::DATA_W-1:0] host_data;
   input  wire logic                               host_oe_n;
   output logic      [eeprom_port_pkg::DATA_W-1:0] bus_level;

   logic [7:0] cells_r [2048];
   logic       unlocked_r = 1'b0;
   logic       drv;

   // =====================================================
   // Array update
   initial begin
      foreach (cells_r[i]) cells_r[i] = 8'h00;
   end
   // done at once, one cell, or every cell when the gate is at high voltage
   always @(negedge write_strobe_n) begin
      unlocked_r = 1'b1;
      if (!chip_sel_n && (out_gate_n || bulk_erase_gate_level)) begin
         if (bulk_erase_gate_level) begin
            foreach (cells_r[i]) cells_r[i] = 8'hFF;
         end else if (host_data === 8'hFF) begin
            cells_r[mem_addr] = 8'hFF;
         end else begin
            // Cells only clear bits, so a missed erase shows up
            cells_r[mem_addr] = cells_r[mem_addr] & host_data;
         end
      end
   end

   // =====================================================
   // Data pins
   // drive only when read and unlocked
   assign drv = !chip_sel_n && !out_gate_n && write_strobe_n && unlocked_r;
   // Released bus shows inverted data so a stale read cannot pass
   assign bus_level = !host_oe_n ? host_data :
                      drv ? cells_r[mem_addr] : ~cells_r[mem_addr];
endmodule : eeprom_dev_model

// >>> dv/test_latched_eeprom_byte_port.sv
// Self-checking bench for the EEPROM host sequencer.
// Assumes short strobe parameters; device model sits on the pins.
module test_latched_eeprom_byte_port;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STD_C = 20;
   localparam int FAST_C = 10;
   localparam int CHIP_C = 30;

   logic                  core_clk, rst, fast_part, req_valid, req_ready, rsp_valid;
   eeprom_port_pkg::cmd_t req_cmd;
   logic [10:0]           req_addr, mem_addr;
   logic [7:0]            req_data, rsp_data, mem_data_in, mem_data_out;
   logic                  chip_sel_n, out_gate_n, bulk_erase_gate_level;
   logic                  write_strobe_n, mem_data_oe_n;
   int                    fails = 0;
   int                    n_tests = 0;
   int                    strb_cnt = 0;

   eeprom_host_ctrl #(.STROBE_STD_CYC(STD_C), .STROBE_FAST_CYC(FAST_C),
      .STROBE_CHIP_CYC(CHIP_C)) u_eeprom_host_ctrl (.core_clk(core_clk), .rst(rst),
      .fast_part(fast_part), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_addr(mem_addr),
      .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
      .bulk_erase_gate_level(bulk_erase_gate_level), .write_strobe_n(write_strobe_n),
      .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
      .mem_data_oe_n(mem_data_oe_n));

   eeprom_dev_model u_eeprom_dev_model (.mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
      .out_gate_n(out_gate_n), .bulk_erase_gate_level(bulk_erase_gate_level),
      .write_strobe_n(write_strobe_n), .host_data(mem_data_out),
      .host_oe_n(mem_data_oe_n), .bus_level(mem_data_in));

   // =====================================================
   // Clock and strobe width
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (write_strobe_n === 1'b0) strb_cnt <= strb_cnt + 1;

   // =====================================================
   // Shared tasks
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic wait_ready;
      int k;
      k = 0;
      while (req_ready !== 1'b1) begin
         @(posedge core_clk);
         k++;
         if (k > 5000) begin
            fails++;
            finish_test;
         end
      end
   endtask : wait_ready

   // Request taken at the first edge, ready having been seen high before it
   task automatic op(input eeprom_port_pkg::cmd_t c, input logic [10:0] a,
                     input logic [7:0] d, output logic [7:0] q, output int lat, output int sw);
      int s0;
      wait_ready;
      s0 = strb_cnt;
      req_valid <= 1'b1;
      req_cmd   <= c;
      req_addr  <= a;
      req_data  <= d;
      @(posedge core_clk);
      req_valid <= 1'b0;
      lat = 0;
      if (c == eeprom_port_pkg::CMD_READ) begin
         while (rsp_valid !== 1'b1 && lat < 100) begin
            @(posedge core_clk);
            lat++;
         end
         if (rsp_valid !== 1'b1) begin
            fails++;
            finish_test;
         end
         q = rsp_data;
      end else begin
         // Ready still shows its pre-take level here
         @(posedge core_clk);
      end
      wait_ready;
      sw = strb_cnt - s0;
   endtask : op

   // =====================================================
   // Scenarios
   task automatic t_reset;
      chk("idle pins", 32'h3C, {chip_sel_n, out_gate_n, write_strobe_n, mem_data_oe_n,
          bulk_erase_gate_level, req_ready});
   endtask : t_reset

   task automatic t_byte;
      logic [7:0] q;
      int         lat, sw;
      op(eeprom_port_pkg::CMD_ERASE, 11'h155, 8'h00, q, lat, sw);
      chk("fast strobe", FAST_C, sw);
      op(eeprom_port_pkg::CMD_WRITE, 11'h155, 8'hA5, q, lat, sw);
      chk("fast write strobe", FAST_C, sw);
      op(eeprom_port_pkg::CMD_READ, 11'h155, 8'h00, q, lat, sw);
      chk("read latency", 26, lat);
      chk("read strobe", 0, sw);
      chk("read byte", 8'hA5, q);
   endtask : t_byte

   task automatic t_neigh;
      logic [7:0] q;
      int         lat, sw;
      fast_part <= 1'b0;
      op(eeprom_port_pkg::CMD_ERASE, 11'h156, 8'h00, q, lat, sw);
      chk("std strobe", STD_C, sw);
      op(eeprom_port_pkg::CMD_WRITE, 11'h156, 8'h3C, q, lat, sw);
      chk("std write strobe", STD_C, sw);
      op(eeprom_port_pkg::CMD_READ, 11'h155, 8'h00, q, lat, sw);
      chk("neighbour", 8'hA5, q);
      op(eeprom_port_pkg::CMD_READ, 11'h156, 8'h00, q, lat, sw);
      chk("second byte", 8'h3C, q);
   endtask : t_neigh

   task automatic t_chip;
      logic [7:0] q;
      int         lat, sw;
      op(eeprom_port_pkg::CMD_CHIP_ERASE, 11'h000, 8'h00, q, lat, sw);
      chk("chip strobe", CHIP_C, sw);
      op(eeprom_port_pkg::CMD_READ, 11'h156, 8'h00, q, lat, sw);
      chk("erased byte", 8'hFF, q);
      op(eeprom_port_pkg::CMD_READ, 11'h155, 8'h00, q, lat, sw);
      chk("erased other byte", 8'hFF, q);
   endtask : t_chip

   // =====================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      fast_part = 1'b1;
      req_valid = 1'b0;
      req_cmd = eeprom_port_pkg::CMD_READ;
      req_addr = 11'h000;
      req_data = 8'h00;
      repeat (3) @(posedge core_clk);
      t_reset;
      rst <= 1'b0;
      @(posedge core_clk);
      t_byte;
      t_neigh;
      t_chip;
      finish_test;
   end
endmodule : test_latched_eeprom_byte_port
